// ==== llbs_pkg.sv ====
/*
 * Shared constants and types of the lead-lag boiler sequencer.
 * Assumes a single 250 MHz system clock and slave status refreshed by the link logic.
 */
package llbs_pkg;

  // Clock and timing.
  localparam longint unsigned CLK_PERIOD_NS = 64'h0000_0000_0000_0004;
  localparam longint unsigned MINUTE_NS     = 64'h0000_000D_F847_5800;
  localparam longint unsigned MINUTE_CYCLES = MINUTE_NS / CLK_PERIOD_NS;
  localparam int              TICK_W        = 36;

  // Field widths.
  localparam int SEQ_W  = 8;
  localparam int RT_W   = 16;
  localparam int RANK_W = 8;

  // Reset values and special codes.
  localparam logic [SEQ_W-1:0]  SEQ_USE_ADDR   = 8'h00;
  localparam logic [SEQ_W-1:0]  LEAD_RESET     = 8'h00;
  localparam logic [RT_W-1:0]   RT_RESET       = 16'h0000;
  localparam logic [RT_W-1:0]   TIME_NONE      = 16'h0000;
  localparam logic [RT_W-1:0]   RT_MAX         = 16'hFFFF;
  localparam logic [RANK_W-1:0] RANK_NONE      = 8'h00;
  localparam logic [1:0]        GROUP_FIRST    = 2'h0;
  localparam logic [1:0]        GROUP_EQUALIZE = 2'h1;
  localparam logic [1:0]        GROUP_LAST     = 2'h2;
  localparam logic [1:0]        GROUP_NONE     = 2'h3;

  typedef enum logic [1:0] {
    LLBS_USE_FIRST,
    LLBS_EQUALIZE,
    LLBS_USE_LAST
  } llbs_mode_t;

  typedef enum logic {
    LLBS_LEAD_BY_SEQ,
    LLBS_LEAD_BY_RUNTIME
  } llbs_lead_pick_t;

  typedef enum logic {
    LLBS_LAG_BY_SEQ,
    LLBS_LAG_BY_RUNTIME
  } llbs_lag_pick_t;

  // Status of one slave as last reported over the link.
  typedef struct packed {
    logic             available;
    logic             firing;
    logic             responding;
    llbs_mode_t       mode;
    logic [SEQ_W-1:0] rank_setting;
    logic [SEQ_W-1:0] address;
    logic [RT_W-1:0]  runtime;
  } llbs_slave_t;

endpackage : llbs_pkg

// ==== llbs_rank_order.sv ====
/*
 * Combinational renumbering of the firing ranks.
 * Assumes the caller registers the result when the stager asks for it.
 */
`timescale 1ns/1ns
`default_nettype none

module llbs_rank_order #(
  parameter int N = 8
) (
  // Current state
  input  wire logic [N-1:0]                    firing,
  input  wire logic [llbs_pkg::RANK_W-1:0]     rank_in  [N],
  // Renumbered ranks
  output var  logic [llbs_pkg::RANK_W-1:0]     rank_out [N]
);

  logic [llbs_pkg::RANK_W-1:0] kept;
  logic [llbs_pkg::RANK_W-1:0] pos;
  logic                        keep_i;
  logic                        keep_j;

  always_comb begin
    kept = llbs_pkg::RANK_NONE;
    pos  = llbs_pkg::RANK_NONE;
    keep_i = 1'b0;
    keep_j = 1'b0;
    for (int i = 0; i < N; i++) begin
      keep_i = firing[i] && (rank_in[i] != llbs_pkg::RANK_NONE);
      kept   = kept + {7'h00, keep_i};
    end
    for (int i = 0; i < N; i++) begin
      keep_i = firing[i] && (rank_in[i] != llbs_pkg::RANK_NONE);
      pos    = llbs_pkg::RANK_NONE;
      for (int j = 0; j < N; j++) begin
        keep_j = firing[j] && (rank_in[j] != llbs_pkg::RANK_NONE);
        if (keep_i) begin
          // Ranked slaves keep their order; equal ranks fall back to table index.
          if (keep_j && ((rank_in[j] < rank_in[i]) ||
                         ((rank_in[j] == rank_in[i]) && (j < i)))) begin
            pos = pos + 8'h01;
          end
        end else if (firing[j] && !keep_j && (j < i)) begin
          pos = pos + 8'h01;
        end
      end
      if (!firing[i]) begin
        rank_out[i] = llbs_pkg::RANK_NONE;
      end else if (keep_i) begin
        rank_out[i] = pos + 8'h01;
      end else begin
        rank_out[i] = kept + pos + 8'h01;
      end
    end
  end

endmodule : llbs_rank_order

`default_nettype wire

// ==== llbs_sequencer.sv ====
/*
 * Lead-lag sequencer: add selection, lead rotation, firing ranks and drop selection.
 * Assumes slave status is synchronous to clk_sys and stable while a request is served.
 */
`timescale 1ns/1ns
`default_nettype none

module llbs_sequencer #(
  parameter int                             N             = 8,
  parameter logic [llbs_pkg::TICK_W-1:0]    MINUTE_CYCLES =
    llbs_pkg::TICK_W'(llbs_pkg::MINUTE_CYCLES)
) (
  // Clock and reset
  input  wire logic                             clk_sys,
  input  wire logic                             resetn,
  // Slave status table
  input  wire llbs_pkg::llbs_slave_t            slaves [N],
  // Settings
  input  wire llbs_pkg::llbs_lead_pick_t        lead_pick_setting,
  input  wire llbs_pkg::llbs_lag_pick_t         lag_pick_setting,
  input  wire logic [llbs_pkg::RT_W-1:0]        rotation_interval,
  input  wire logic [llbs_pkg::RT_W-1:0]        forced_rotation_interval,
  // Stager requests
  input  wire logic                             add_req,
  input  wire logic                             drop_req,
  input  wire logic                             order_req,
  // Add answer
  output logic                                  add_done,
  output logic                                  add_found,
  output logic [$clog2(N)-1:0]                  add_id,
  // Drop answer
  output logic                                  drop_done,
  output logic                                  drop_found,
  output logic [$clog2(N)-1:0]                  drop_id,
  // Sequencer state
  output logic [llbs_pkg::SEQ_W-1:0]            lead_index,
  output logic [llbs_pkg::RT_W-1:0]             lead_runtime_minutes,
  output logic [llbs_pkg::RANK_W-1:0]           firing_rank [N],
  output logic                                  forced_rotation,
  output logic [llbs_pkg::SEQ_W-1:0]            forced_old_lead,
  output logic                                  dup_alert
);

  localparam int IW = $clog2(N);

  typedef enum {
    ST_IDLE,
    ST_ROTATE,
    ST_PICK
  } llbs_state_t;

  ////////////////////////////////////////////////////////////////////////////////

  // Effective sequence number of one slave.
  function automatic logic [llbs_pkg::SEQ_W-1:0] eff_seq(input llbs_pkg::llbs_slave_t s);
    eff_seq = (s.rank_setting == llbs_pkg::SEQ_USE_ADDR) ? s.address : s.rank_setting;
  endfunction : eff_seq

  // A slave that may be designated lead.
  function automatic logic lead_ok(input llbs_pkg::llbs_slave_t s);
    lead_ok = s.responding && (s.mode == llbs_pkg::LLBS_EQUALIZE);
  endfunction : lead_ok

  // Next lead number under sequence rotation.
  function automatic logic [llbs_pkg::SEQ_W-1:0] rot_by_seq(
    input llbs_pkg::llbs_slave_t      sl [N],
    input logic [llbs_pkg::SEQ_W-1:0] idx
  );
    logic [llbs_pkg::SEQ_W-1:0] tgt;
    logic [llbs_pkg::SEQ_W-1:0] best_ge;
    logic [llbs_pkg::SEQ_W-1:0] best_min;
    logic [llbs_pkg::SEQ_W-1:0] e;
    logic                       got_ge;
    logic                       got_any;
    tgt      = idx + 8'h01;
    best_ge  = tgt;
    best_min = tgt;
    got_ge   = 1'b0;
    got_any  = 1'b0;
    for (int i = 0; i < N; i++) begin
      e = eff_seq(sl[i]);
      if (lead_ok(sl[i])) begin
        if ((e >= tgt) && (!got_ge || (e < best_ge))) begin
          best_ge = e;
          got_ge  = 1'b1;
        end
        if (!got_any || (e < best_min)) begin
          best_min = e;
          got_any  = 1'b1;
        end
      end
    end
    rot_by_seq = got_ge ? best_ge : (got_any ? best_min : tgt);
  endfunction : rot_by_seq

  // Lead number of the lowest measured run time.
  function automatic logic [llbs_pkg::SEQ_W-1:0] rot_by_runtime(
    input llbs_pkg::llbs_slave_t      sl [N],
    input logic [llbs_pkg::SEQ_W-1:0] idx
  );
    logic [llbs_pkg::RT_W-1:0] best_rt;
    logic                      got;
    rot_by_runtime = idx;
    best_rt        = llbs_pkg::RT_MAX;
    got            = 1'b0;
    for (int i = 0; i < N; i++) begin
      // Strict compare keeps the lowest index among equal run times.
      if (lead_ok(sl[i]) && (!got || (sl[i].runtime < best_rt))) begin
        best_rt        = sl[i].runtime;
        rot_by_runtime = eff_seq(sl[i]);
        got            = 1'b1;
      end
    end
  endfunction : rot_by_runtime

  ////////////////////////////////////////////////////////////////////////////////

  llbs_state_t                 state;
  logic [llbs_pkg::TICK_W-1:0] tick_cnt;
  logic                        tick;
  logic                        lead_found;
  logic [IW-1:0]               lead_slot;
  logic                        lead_firing;
  logic                        lead_usable;
  logic                        vol_rotate;
  logic                        force_rotate;
  logic [llbs_pkg::RT_W-1:0]   next_runtime;
  logic [llbs_pkg::SEQ_W-1:0]  next_lead;
  logic [N-1:0]                firing_vec;
  logic [llbs_pkg::RANK_W-1:0] next_rank [N];

  // Lead lookup: first equalize slave whose number matches the lead index.
  always_comb begin
    lead_found = 1'b0;
    lead_slot  = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if ((slaves[i].mode == llbs_pkg::LLBS_EQUALIZE) && (eff_seq(slaves[i]) == lead_index)) begin
        lead_found = 1'b1;
        lead_slot  = IW'(i);
      end
    end
  end

  assign lead_firing = lead_found && slaves[lead_slot].firing;
  assign lead_usable = lead_found && (slaves[lead_slot].available || slaves[lead_slot].firing);

  // Voluntary rotation test, applied once per add request.
  assign vol_rotate = (state == ST_ROTATE) &&
                      (!lead_usable ||
                       ((rotation_interval != llbs_pkg::TIME_NONE) &&
                        (lead_runtime_minutes > rotation_interval)));

  // Run time after this tick, saturating.
  assign next_runtime = (lead_runtime_minutes == llbs_pkg::RT_MAX) ?
                        lead_runtime_minutes : lead_runtime_minutes + 16'h0001;

  assign force_rotate = tick && lead_firing &&
                        (forced_rotation_interval != llbs_pkg::TIME_NONE) &&
                        (next_runtime >= forced_rotation_interval);

  assign next_lead = (lead_pick_setting == llbs_pkg::LLBS_LEAD_BY_SEQ) ?
                     rot_by_seq(slaves, lead_index) :
                     rot_by_runtime(slaves, lead_index);

  ////////////////////////////////////////////////////////////////////////////////

  // Minute timing service.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == MINUTE_CYCLES - 36'h0_0000_0001) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 36'h0_0000_0001;
      tick     <= 1'b0;
    end
  end

  // Lead designation and its accumulated run time.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lead_index           <= llbs_pkg::LEAD_RESET;
      lead_runtime_minutes <= llbs_pkg::RT_RESET;
      forced_rotation      <= 1'b0;
      forced_old_lead      <= llbs_pkg::LEAD_RESET;
    end else begin
      forced_rotation <= force_rotate;
      if (force_rotate) begin
        forced_old_lead <= lead_index;
      end
      if (vol_rotate || force_rotate) begin
        // Designation only; firing states of the slaves are not touched.
        lead_index           <= next_lead;
        lead_runtime_minutes <= llbs_pkg::RT_RESET;
      end else if (tick && lead_firing) begin
        lead_runtime_minutes <= next_runtime;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Add request sequencing: rotate once, then pick on the updated lead.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (add_req) begin
            state <= ST_ROTATE;
          end
        end
        ST_ROTATE: begin
          state <= ST_PICK;
        end
        ST_PICK: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Ordering key of each available slave; lowest key is added first.
  logic [18:0]   add_key;
  logic [18:0]   best_key;
  logic          best_got;
  logic [IW-1:0] best_slot;
  logic [1:0]    grp;
  logic          not_lead;
  logic [15:0]   sub;

  always_comb begin
    add_key   = '0;
    best_key  = '1;
    best_got  = 1'b0;
    best_slot = '0;
    grp       = llbs_pkg::GROUP_NONE;
    not_lead  = 1'b0;
    sub       = '0;
    for (int i = 0; i < N; i++) begin
      not_lead = 1'b0;
      sub      = {8'h00, eff_seq(slaves[i])};
      case (slaves[i].mode)
        llbs_pkg::LLBS_USE_FIRST: grp = llbs_pkg::GROUP_FIRST;
        llbs_pkg::LLBS_EQUALIZE: begin
          grp = llbs_pkg::GROUP_EQUALIZE;
          if (lead_found && (IW'(i) == lead_slot)) begin
            sub = '0;
          end else begin
            not_lead = 1'b1;
            if (lag_pick_setting == llbs_pkg::LLBS_LAG_BY_RUNTIME) begin
              sub = slaves[i].runtime;
            end
          end
        end
        llbs_pkg::LLBS_USE_LAST: grp = llbs_pkg::GROUP_LAST;
        default: grp = llbs_pkg::GROUP_NONE;
      endcase
      add_key = {grp, not_lead, sub};
      // Strict compare: equal keys keep the lowest table index.
      if (slaves[i].available && (grp != llbs_pkg::GROUP_NONE) &&
          (!best_got || (add_key < best_key))) begin
        best_key  = add_key;
        best_slot = IW'(i);
        best_got  = 1'b1;
      end
    end
  end

  // Add answer.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      add_done  <= 1'b0;
      add_found <= 1'b0;
      add_id    <= '0;
    end else begin
      add_done <= (state == ST_PICK);
      if (state == ST_PICK) begin
        add_found <= best_got;
        add_id    <= best_slot;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Firing ranks, renumbered just before each stager run.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      firing_vec[i] = slaves[i].firing;
    end
  end

  llbs_rank_order #(
    .N        (N)
  ) u_rank_order (
    .firing   (firing_vec),
    .rank_in  (firing_rank),
    .rank_out (next_rank)
  );

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < N; i++) begin
        firing_rank[i] <= llbs_pkg::RANK_NONE;
      end
    end else if (order_req) begin
      for (int i = 0; i < N; i++) begin
        firing_rank[i] <= next_rank[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Drop selection over the firing slaves.
  logic [IW:0]                 fire_cnt;
  logic [llbs_pkg::RANK_W-1:0] top_rank;
  logic [IW-1:0]               top_slot;
  logic                        top_got;

  always_comb begin
    fire_cnt = '0;
    top_rank = llbs_pkg::RANK_NONE;
    top_slot = '0;
    top_got  = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (slaves[i].firing) begin
        fire_cnt = fire_cnt + (IW + 1)'(1);
        if (!top_got || (firing_rank[i] > top_rank)) begin
          top_rank = firing_rank[i];
          top_slot = IW'(i);
          top_got  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drop_done  <= 1'b0;
      drop_found <= 1'b0;
      drop_id    <= '0;
    end else begin
      drop_done <= drop_req;
      if (drop_req) begin
        drop_found <= (fire_cnt > (IW + 1)'(1));
        drop_id    <= top_slot;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Alert on two slaves sharing mode and effective sequence number.
  logic dup_any;

  always_comb begin
    dup_any = 1'b0;
    for (int i = 0; i < N; i++) begin
      for (int j = i + 1; j < N; j++) begin
        if ((slaves[i].mode == slaves[j].mode) &&
            (eff_seq(slaves[i]) == eff_seq(slaves[j]))) begin
          dup_any = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dup_alert <= 1'b0;
    end else begin
      dup_alert <= dup_any;
    end
  end

endmodule : llbs_sequencer

`default_nettype wire

// ==== llbs_sequencer_props.sv ====
/*
 * Concurrent checks of the sequencer's answers at its ports.
 * Assumes slave status stays still around each request.
 */
`timescale 1ns/1ns
`default_nettype none

module llbs_sequencer_props #(
  parameter int                          N             = 8,
  parameter logic [llbs_pkg::TICK_W-1:0] MINUTE_CYCLES =
    llbs_pkg::TICK_W'(llbs_pkg::MINUTE_CYCLES)
) (
  // Clock and reset
  input wire logic                        clk_sys,
  input wire logic                        resetn,
  // Sequencer inputs
  input wire llbs_pkg::llbs_slave_t       slaves [N],
  input wire logic [llbs_pkg::RT_W-1:0]   forced_rotation_interval,
  input wire logic                        add_req,
  input wire logic                        drop_req,
  input wire logic                        order_req,
  // Sequencer outputs
  input wire logic                        add_done,
  input wire logic                        drop_done,
  input wire logic                        drop_found,
  input wire logic [$clog2(N)-1:0]        drop_id,
  input wire logic [llbs_pkg::RT_W-1:0]   lead_runtime_minutes,
  input wire logic [llbs_pkg::RANK_W-1:0] firing_rank [N],
  input wire logic                        forced_rotation
);
  int   n_fire;
  int   max_rank;
  logic nf_zero;
  logic f_set;

  // Counts firing slaves and summarises their ranks.
  always_comb begin
    n_fire = 0;
    max_rank = 0;
    nf_zero = 1'b1;
    f_set = 1'b1;
    for (int i = 0; i < N; i++) begin
      if (slaves[i].firing) begin
        n_fire++;
        if (firing_rank[i] == '0) f_set = 1'b0;
        if (int'(firing_rank[i]) > max_rank) max_rank = int'(firing_rank[i]);
      end else if (firing_rank[i] != '0) begin
        nf_zero = 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  AST_ADD_LAT: assert property (add_done |-> $past(add_req, 3))
    else $error("add answer without a request three cycles before");
  AST_ADD_PULSE: assert property (add_done |=> !add_done)
    else $error("add answer held longer than one cycle");
  AST_DROP_LAT: assert property (drop_req |=> drop_done)
    else $error("drop answer missing");
  AST_DROP_NONE: assert property (drop_req && n_fire < 2 |=> !drop_found)
    else $error("drop offered with fewer than two firing");
  AST_DROP_ID: assert property (drop_req && n_fire >= 2 |=>
    drop_found && int'(firing_rank[drop_id]) == max_rank)
    else $error("dropped slave is not the highest rank");
  AST_RANK_CLEAR: assert property (order_req |=> nf_zero)
    else $error("idle slave kept a rank");
  AST_RANK_FILL: assert property (order_req |=> f_set && max_rank == n_fire)
    else $error("ranks not consecutive from one");
  AST_ROT_CLEAR: assert property (forced_rotation |-> lead_runtime_minutes == '0)
    else $error("runtime not cleared by rotation");
  AST_RT_STEP: assert property ($changed(lead_runtime_minutes) |->
    lead_runtime_minutes == '0 ||
    lead_runtime_minutes == $past(lead_runtime_minutes) + 1'b1)
    else $error("lead runtime moved by more than one");
  AST_FORCE_OFF: assert property (forced_rotation |-> $past(forced_rotation_interval) != '0)
    else $error("forced rotation while disabled");

  COV_ADD: cover property (add_done);
  COV_DROP: cover property (drop_done && drop_found);
  COV_FORCE: cover property (forced_rotation);
endmodule : llbs_sequencer_props

bind llbs_sequencer llbs_sequencer_props #(.N(N), .MINUTE_CYCLES(MINUTE_CYCLES)) u_props (
  .clk_sys, .resetn, .slaves, .forced_rotation_interval, .add_req, .drop_req, .order_req,
  .add_done, .drop_done, .drop_found, .drop_id, .lead_runtime_minutes, .firing_rank,
  .forced_rotation);

`default_nettype wire

// ==== llbs_slave_model.sv ====
/*
 * Behavioural model of the slave boilers' reported status table.
 * Assumes the bench writes one entry per update, synchronous to clk_sys.
 */
`timescale 1ns/1ns
`default_nettype none

module llbs_slave_model #(
  parameter int N = 8
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  // Entry update
  input  wire logic                  set_en,
  input  wire logic [$clog2(N)-1:0]  set_idx,
  input  wire llbs_pkg::llbs_slave_t set_val,
  // Status table
  output var  llbs_pkg::llbs_slave_t slaves [N]
);
  // A slave that has never reported looks absent and silent.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < N; i++) begin
        slaves[i] <= '0;
      end
    end else if (set_en) begin
      slaves[set_idx] <= set_val;
    end
  end
endmodule : llbs_slave_model

`default_nettype wire

// ==== test_llbs_sequencer.sv ====
/*
 * Self-checking bench: add order, rotation, ranks, drop and duplicate alert.
 * Assumes the slave model holds the status table and a 16-cycle minute.
 */
`timescale 1ns/1ns
`default_nettype none

module test_llbs_sequencer;
  logic                      clk_sys = 1'b0;
  logic                      resetn = 1'b0;
  llbs_pkg::llbs_lead_pick_t lead_pick_setting = llbs_pkg::LLBS_LEAD_BY_SEQ;
  llbs_pkg::llbs_lag_pick_t  lag_pick_setting = llbs_pkg::LLBS_LAG_BY_SEQ;
  logic [15:0]               rotation_interval = 16'h0000;
  logic [15:0]               forced_rotation_interval = 16'h0000;
  logic                      add_req = 1'b0;
  logic                      drop_req = 1'b0;
  logic                      order_req = 1'b0;
  logic                      set_en = 1'b0;
  logic [2:0]                set_idx = 3'h0;
  llbs_pkg::llbs_slave_t     set_val = '0;
  llbs_pkg::llbs_slave_t     slaves [8];
  llbs_pkg::llbs_slave_t     tbl [8];
  logic                      add_done, add_found, drop_done, drop_found;
  logic                      forced_rotation, dup_alert;
  logic [2:0]                add_id, drop_id;
  logic [7:0]                lead_index, forced_old_lead;
  logic [15:0]               lead_runtime_minutes;
  logic [7:0]                firing_rank [8];
  logic [7:0]                exp_rank [8] = '{8'h01, 8'h00, 8'h02, 8'h00, 8'h03, 8'h04,
                                              8'h05, 8'h00};
  int                        err_total = 0;
  int                        tests_run = 0;

  llbs_slave_model #(.N(8)) u_model (.clk_sys, .resetn, .set_en, .set_idx, .set_val, .slaves);

  llbs_sequencer #(.N(8), .MINUTE_CYCLES(36'h0_0000_0010)) uut (
    .clk_sys, .resetn, .slaves, .lead_pick_setting, .lag_pick_setting, .rotation_interval,
    .forced_rotation_interval, .add_req, .drop_req, .order_req, .add_done, .add_found,
    .add_id, .drop_done, .drop_found, .drop_id, .lead_index, .lead_runtime_minutes,
    .firing_rank, .forced_rotation, .forced_old_lead, .dup_alert);

  always #2 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task automatic upd(input int i);
    @(posedge clk_sys);
    set_en <= 1'b1;
    set_idx <= 3'(i);
    set_val <= tbl[i];
    @(posedge clk_sys);
    set_en <= 1'b0;
  endtask : upd

  // A firing slave is no longer offered for adding.
  task automatic fire(input int i);
    tbl[i].available = 1'b0;
    tbl[i].firing = 1'b1;
    upd(i);
  endtask : fire

  task automatic idle(input int i);
    tbl[i].firing = 1'b0;
    upd(i);
  endtask : idle

  // Raises one request for a single cycle: 0 add, 1 drop, 2 order.
  task automatic pulse(input int k);
    @(posedge clk_sys);
    add_req   <= (k == 0);
    drop_req  <= (k == 1);
    order_req <= (k == 2);
    @(posedge clk_sys);
    {add_req, drop_req, order_req} <= 3'h0;
  endtask : pulse

  task automatic add(input logic f, input logic [2:0] id);
    pulse(0);
    repeat (2) @(posedge clk_sys);
    #1;
    check(add_done, 1'b1);
    check(add_found, f);
    if (f) check(add_id, id);
  endtask : add

  task automatic drop(input logic f, input logic [2:0] id);
    pulse(1);
    #1;
    check(drop_done, 1'b1);
    check(drop_found, f);
    if (f) check(drop_id, id);
  endtask : drop

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    test_done();
  end

  initial begin
    for (int i = 0; i < 8; i++) begin
      tbl[i] = '{1'b0, 1'b0, 1'b0, llbs_pkg::LLBS_USE_LAST, 8'h00, 8'(8'h10 + i), 16'h0000};
    end
    tbl[0] = '{1'b1, 1'b0, 1'b1, llbs_pkg::LLBS_USE_LAST, 8'h01, 8'h09, 16'h0000};
    tbl[1] = '{1'b1, 1'b0, 1'b1, llbs_pkg::LLBS_EQUALIZE, 8'h00, 8'h03, 16'h012C};
    tbl[2] = '{1'b1, 1'b0, 1'b1, llbs_pkg::LLBS_EQUALIZE, 8'h05, 8'h0A, 16'h00C8};
    tbl[3] = '{1'b1, 1'b0, 1'b1, llbs_pkg::LLBS_USE_FIRST, 8'h07, 8'h0B, 16'h0000};
    tbl[4] = '{1'b1, 1'b0, 1'b1, llbs_pkg::LLBS_USE_FIRST, 8'h02, 8'h0C, 16'h0000};
    tbl[5] = '{1'b1, 1'b0, 1'b1, llbs_pkg::LLBS_EQUALIZE, 8'h08, 8'h0D, 16'h0032};
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) upd(i);
    add(1'b1, 3'h4);
    check(lead_index, 8'h03);
    fire(4);
    fire(3);
    add(1'b1, 3'h1);
    fire(1);
    add(1'b1, 3'h2);
    check(lead_index, 8'h03);
    @(posedge clk_sys);
    lag_pick_setting <= llbs_pkg::LLBS_LAG_BY_RUNTIME;
    add(1'b1, 3'h5);
    fire(2);
    fire(5);
    add(1'b1, 3'h0);
    fire(0);
    add(1'b0, 3'h0);
    pulse(2);
    #1;
    for (int i = 0; i < 8; i++) check(firing_rank[i], i < 6 ? 8'(i + 1) : 8'h00);
    idle(1);
    idle(3);
    fire(6);
    pulse(2);
    #1;
    for (int i = 0; i < 8; i++) check(firing_rank[i], exp_rank[i]);
    drop(1'b1, 3'h6);
    idle(2);
    idle(4);
    idle(5);
    idle(6);
    drop(1'b0, 3'h0);
    fire(1);
    @(posedge clk_sys);
    forced_rotation_interval <= 16'h0003;
    for (int k = 0; k < 300 && forced_rotation !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    check(forced_rotation, 1'b1);
    check(forced_old_lead, 8'h03);
    check(lead_index, 8'h05);
    check(lead_runtime_minutes, 16'h0000);
    @(posedge clk_sys);
    forced_rotation_interval <= 16'h0000;
    rotation_interval <= 16'h0001;
    fire(2);
    for (int k = 0; k < 300 && lead_runtime_minutes !== 16'h0002; k++) begin
      @(posedge clk_sys);
      #1;
    end
    check(lead_runtime_minutes, 16'h0002);
    @(posedge clk_sys);
    lead_pick_setting <= llbs_pkg::LLBS_LEAD_BY_RUNTIME;
    add(1'b0, 3'h0);
    check(lead_index, 8'h08);
    check(lead_runtime_minutes, 16'h0000);
    @(posedge clk_sys);
    lead_pick_setting <= llbs_pkg::LLBS_LEAD_BY_SEQ;
    tbl[5].responding = 1'b0;
    upd(5);
    add(1'b0, 3'h0);
    check(lead_index, 8'h03);
    check(dup_alert, 1'b0);
    tbl[6].mode = llbs_pkg::LLBS_EQUALIZE;
    tbl[6].rank_setting = 8'h05;
    upd(6);
    repeat (2) @(posedge clk_sys);
    #1;
    check(dup_alert, 1'b1);
    test_done();
  end
endmodule : test_llbs_sequencer

`default_nettype wire
